// file: rtl/cev_core_event.sv
// Core event stage with routing, register slave and vectoring
`timescale 1ns/100ps
module cev_core_event #(
  parameter int NUM_SRC = 16
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_supervisor_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire cev_pkg::cev_evt_req_t evt_in,
  input wire logic [NUM_SRC-1:0] periph_irq_in,
  input wire logic take_ready_in,
  input wire logic [31:0] pc_in,
  input wire logic rte_in,
  input wire logic [3:0] rte_level_in,
  output cev_pkg::cev_entry_t entry_out,
  output logic save_state_out,
  output logic emu_mode_out,
  output logic core_reset_out,
  output logic [31:0] resume_addr_out,
  output logic resume_out
);
  logic [15:0] latch;
  logic [15:0] mask;
  logic [15:0] pend;
  logic [NUM_SRC-1:0] rmask;
  logic [4*NUM_SRC-1:0] rassign;
  logic [31:0] vec_tab [cev_pkg::NUM_LEVELS];
  logic [31:0] ret_addr [cev_pkg::NUM_LEVELS];
  logic nmi_meta;
  logic nmi_sync;
  logic [15:0] raw;
  logic [15:0] raw_prev;
  logic [15:0] set_bits;
  logic [15:0] eff_mask;
  logic [15:0] cand;
  logic [NUM_SRC-1:0] rstat;
  logic [8:0] gen_lvls;
  logic c_found;
  logic [3:0] c_idx;
  logic p_found;
  logic [3:0] p_idx;
  logic take;
  logic [15:0] take_bit;
  logic ack;
  logic req;
  logic wr_go;
  logic sup_wr;
  logic [15:0] wr_clear;
  logic [15:0] wr_raise;
  logic [31:0] next_rdata;

  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] onehot16(input logic [3:0] i);
    return 16'h0001 << i;
  endfunction

  // Pin synchroniser for the nonmaskable input
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      nmi_meta <= 1'b0;
      nmi_sync <= 1'b0;
    end
    else
    begin
      nmi_meta <= evt_in.nmi_pin;
      nmi_sync <= nmi_meta;
    end
  end

  cev_irq_router #(
    .NUM_SRC(NUM_SRC)
  ) u_router (
    .src_in(periph_irq_in),
    .src_mask_in(rmask),
    .assign_in(rassign),
    .status_out(rstat),
    .gen_out(gen_lvls)
  );

  always_comb
  begin
    raw = 16'h0000;
    raw[cev_pkg::LVL_EMU] = evt_in.emu;
    raw[cev_pkg::LVL_RST] = evt_in.rst;
    raw[cev_pkg::LVL_NMI] = nmi_sync | evt_in.wdog;
    raw[cev_pkg::LVL_EXC] = evt_in.exc;
    raw[cev_pkg::LVL_HWERR] = evt_in.hwerr;
    raw[cev_pkg::LVL_TMR] = evt_in.tmr;
    raw[15:7] = gen_lvls;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      raw_prev <= 16'h0000;
    end
    else
    begin
      raw_prev <= raw;
    end
  end

  assign set_bits = (raw & ~raw_prev) | wr_raise;

  assign eff_mask = mask | cev_pkg::NONMASK_BITS;
  assign cand = latch & eff_mask;

  cev_prio_enc #(
    .W(16)
  ) u_cand (
    .req_in(cand),
    .found_out(c_found),
    .idx_out(c_idx)
  );

  cev_prio_enc #(
    .W(16)
  ) u_cur (
    .req_in(pend),
    .found_out(p_found),
    .idx_out(p_idx)
  );

  // Nest only above the active level
  assign take = c_found && take_ready_in && (!p_found || c_idx < p_idx);
  assign take_bit = take ? onehot16(c_idx) : 16'h0000;

  // Bus slave handshake
  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack;
  assign wr_go = avs_write_in & ack;
  assign sup_wr = wr_go & avs_supervisor_in;
  assign wr_clear = (sup_wr && avs_address_in == cev_pkg::OFF_LATCH) ?
    (avs_writedata_in[15:0] & ~eff_mask) : 16'h0000;
  assign wr_raise = (sup_wr && avs_address_in == cev_pkg::OFF_RAISE) ?
    (avs_writedata_in[15:0] & cev_pkg::GEN_BITS) : 16'h0000;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= req & ~ack;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      latch <= cev_pkg::RST_LATCH;
    end
    else
    begin
      latch <= (latch & ~take_bit & ~wr_clear) | set_bits;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      mask <= cev_pkg::RST_MASK;
    end
    else if (sup_wr && avs_address_in == cev_pkg::OFF_MASK)
    begin
      mask <= 16'(merge_be({16'h0000, mask}, avs_writedata_in,
                           avs_byteenable_in));
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      pend <= cev_pkg::RST_PEND;
    end
    else if (take && c_idx == cev_pkg::LVL_RST)
    begin
      pend <= onehot16(cev_pkg::LVL_RST);
    end
    else
    begin
      pend <= (pend & ~((rte_in) ? onehot16(rte_level_in) : 16'h0000))
              | take_bit;
    end
  end

  // Routing stage configuration
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      rmask <= cev_pkg::RST_RMASK[NUM_SRC-1:0];
      rassign <= {2{cev_pkg::RST_ASSIGN}};
    end
    else if (sup_wr)
    begin
      if (avs_address_in == cev_pkg::OFF_RMASK)
      begin
        rmask <= NUM_SRC'(merge_be({{(32-NUM_SRC){1'b0}}, rmask},
                                   avs_writedata_in, avs_byteenable_in));
      end
      if (avs_address_in == cev_pkg::OFF_ASSIGN0)
      begin
        rassign[31:0] <= merge_be(rassign[31:0], avs_writedata_in,
                                  avs_byteenable_in);
      end
      if (avs_address_in == cev_pkg::OFF_ASSIGN1)
      begin
        rassign[63:32] <= merge_be(rassign[63:32], avs_writedata_in,
                                   avs_byteenable_in);
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < cev_pkg::NUM_LEVELS; i++)
      begin
        vec_tab[i] <= cev_pkg::RST_VEC;
      end
    end
    else if (sup_wr && avs_address_in[7:6] == cev_pkg::OFF_VEC_BASE[7:6])
    begin
      vec_tab[avs_address_in[5:2]] <= merge_be(vec_tab[avs_address_in[5:2]],
                                               avs_writedata_in,
                                               avs_byteenable_in);
    end
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (avs_supervisor_in)
    begin
      unique case (avs_address_in)
        cev_pkg::OFF_LATCH: next_rdata = {16'h0000, latch};
        cev_pkg::OFF_MASK: next_rdata = {16'h0000, eff_mask};
        cev_pkg::OFF_PEND: next_rdata = {16'h0000, pend};
        cev_pkg::OFF_RMASK: next_rdata = 32'(rmask);
        cev_pkg::OFF_RSTAT: next_rdata = 32'(rstat);
        cev_pkg::OFF_ASSIGN0: next_rdata = rassign[31:0];
        cev_pkg::OFF_ASSIGN1: next_rdata = rassign[63:32];
        default:
        begin
          if (avs_address_in[7:6] == cev_pkg::OFF_VEC_BASE[7:6])
          begin
            next_rdata = vec_tab[avs_address_in[5:2]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      avs_readdata_out <= 32'h0000_0000;
    end
    else if (avs_read_in && !ack)
    begin
      avs_readdata_out <= next_rdata;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      entry_out <= '0;
      save_state_out <= 1'b0;
    end
    else
    begin
      entry_out.take <= take;
      entry_out.level <= take ? c_idx : entry_out.level;
      entry_out.vector <= take ? vec_tab[c_idx] : entry_out.vector;
      save_state_out <= take;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < cev_pkg::NUM_LEVELS; i++)
      begin
        ret_addr[i] <= 32'h0000_0000;
      end
    end
    else if (take)
    begin
      ret_addr[c_idx] <= pc_in;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      resume_out <= 1'b0;
      resume_addr_out <= 32'h0000_0000;
    end
    else
    begin
      resume_out <= rte_in;
      resume_addr_out <= rte_in ? ret_addr[rte_level_in] : resume_addr_out;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      emu_mode_out <= 1'b0;
      core_reset_out <= 1'b0;
    end
    else
    begin
      core_reset_out <= take && c_idx == cev_pkg::LVL_RST;
      if (take && c_idx == cev_pkg::LVL_EMU)
      begin
        emu_mode_out <= 1'b1;
      end
      else if (rte_in && rte_level_in == cev_pkg::LVL_EMU)
      begin
        emu_mode_out <= 1'b0;
      end
    end
  end

  a_take_nest: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    take && p_found && !rte_in && c_idx != cev_pkg::LVL_RST |=>
      pend[$past(p_idx)] && pend[$past(c_idx)])
    else $error("nested entry dropped the active level");
  a_take_highest: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    take |-> (cand & (onehot16(c_idx) - 16'h0001)) == 16'h0000)
    else $error("lower priority taken first");
  a_emu_mode_set: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    take && c_idx == cev_pkg::LVL_EMU |=> emu_mode_out)
    else $error("emulation mode not entered");
  a_core_reset_pulse: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    take && c_idx == cev_pkg::LVL_RST |=>
      core_reset_out && pend == onehot16(cev_pkg::LVL_RST))
    else $error("reset entry wrong");
  a_nmi_pin_latch: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    $rose(nmi_sync) |=> latch[cev_pkg::LVL_NMI])
    else $error("nonmaskable not latched");
  a_latch_accept: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    take && !set_bits[c_idx] |=> !latch[$past(c_idx)])
    else $error("accepted latch bit not cleared");
  a_mask_blocks: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    take |-> latch[c_idx] && (mask[c_idx] || c_idx <= cev_pkg::LVL_EXC))
    else $error("masked event taken");
  a_pend_entry: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    take |=> pend[$past(c_idx)] && entry_out.take && save_state_out)
    else $error("pending or entry strobe missing");
  a_vector_out: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    take |=> entry_out.level == $past(c_idx) &&
      entry_out.vector == $past(vec_tab[c_idx]))
    else $error("wrong vector supplied");
  a_resume_addr: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    rte_in && !take |=> resume_out &&
      resume_addr_out == ret_addr[$past(rte_level_in)])
    else $error("resume address wrong");
  a_user_reserved: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    avs_read_in && !ack && !avs_supervisor_in |=> avs_readdata_out == 0)
    else $error("non-supervisor read saw data");
endmodule

// file: rtl/cev_pkg.sv
// Package of constants and carrier types for the core event controller
package cev_pkg;
  localparam int NUM_LEVELS = 16;
  localparam int LVL_W = 4;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [3:0] LVL_EMU = 4'h0;
  localparam logic [3:0] LVL_RST = 4'h1;
  localparam logic [3:0] LVL_NMI = 4'h2;
  localparam logic [3:0] LVL_EXC = 4'h3;
  localparam logic [3:0] LVL_HWERR = 4'h5;
  localparam logic [3:0] LVL_TMR = 4'h6;
  localparam logic [3:0] LVL_GEN_LO = 4'h7;
  localparam int NUM_GEN = 9;
  localparam logic [15:0] NONMASK_BITS = 16'h000f;
  localparam logic [15:0] GEN_BITS = 16'hff80;
  localparam logic [7:0] OFF_LATCH = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_PEND = 8'h08;
  localparam logic [7:0] OFF_RAISE = 8'h0c;
  localparam logic [7:0] OFF_RMASK = 8'h10;
  localparam logic [7:0] OFF_RSTAT = 8'h14;
  localparam logic [7:0] OFF_ASSIGN0 = 8'h18;
  localparam logic [7:0] OFF_ASSIGN1 = 8'h1c;
  localparam logic [7:0] OFF_VEC_BASE = 8'h40;
  localparam logic [15:0] RST_LATCH = 16'h0000;
  localparam logic [15:0] RST_MASK = 16'h001f;
  localparam logic [15:0] RST_PEND = 16'h0000;
  localparam logic [31:0] RST_RMASK = 32'h0000_0000;
  localparam logic [31:0] RST_ASSIGN = 32'h0000_0000;
  localparam logic [31:0] RST_VEC = 32'h0000_0000;

  typedef struct packed {
    logic emu;
    logic rst;
    logic nmi_pin;
    logic wdog;
    logic exc;
    logic hwerr;
    logic tmr;
  } cev_evt_req_t;

  typedef struct packed {
    logic take;
    logic [3:0] level;
    logic [31:0] vector;
  } cev_entry_t;
endpackage

// file: rtl/cev_prio_enc.sv
// Fixed priority encoder, lowest index wins
`timescale 1ns/100ps
module cev_prio_enc #(
  parameter int W = 16
) (
  input wire logic [W-1:0] req_in,
  output logic found_out,
  output logic [3:0] idx_out
);
  always_comb
  begin
    found_out = 1'b0;
    idx_out = 4'h0;
    for (int i = W - 1; i >= 0; i--)
    begin
      if (req_in[i])
      begin
        found_out = 1'b1;
        idx_out = 4'(i);
      end
    end
  end
endmodule

// file: rtl/cev_irq_router.sv
// Routing stage from peripheral requests to the general levels
`timescale 1ns/100ps
module cev_irq_router #(
  parameter int NUM_SRC = 16
) (
  input wire logic [NUM_SRC-1:0] src_in,
  input wire logic [NUM_SRC-1:0] src_mask_in,
  input wire logic [4*NUM_SRC-1:0] assign_in,
  output logic [NUM_SRC-1:0] status_out,
  output logic [8:0] gen_out
);
  logic [3:0] sel;
  assign status_out = src_in & src_mask_in;
  // Map each unmasked source to its assigned level, if below 9
  always_comb
  begin
    gen_out = 9'h000;
    sel = 4'h0;
    for (int s = 0; s < NUM_SRC; s++)
    begin
      sel = assign_in[4*s +: 4];
      if (status_out[s] && sel < 4'(cev_pkg::NUM_GEN))
      begin
        gen_out[sel] = 1'b1;
      end
    end
  end
endmodule

// file: dv/cev_core_model.sv
// Core sequencer model that accepts entries and keeps return addresses
`timescale 1ns/100ps
module cev_core_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire cev_pkg::cev_entry_t entry_in,
  output logic take_ready_out,
  output logic [31:0] pc_out,
  output logic [31:0] saved_out [16]
);
  logic tog;
  // Stalls every other cycle when slow
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      tog <= 1'b0;
    else
      tog <= ~tog;
  end
  assign take_ready_out = ~slow_in | tog;
  // Program counter moves on after each entry
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      pc_out <= 32'h0000_4000;
    else if (entry_in.take)
    begin
      saved_out[entry_in.level] <= pc_out;
      pc_out <= pc_out + 32'h0000_0010;
    end
  end
endmodule

// file: dv/cev_core_event_tb.sv
// Self-checking bench for the core event stage
`timescale 1ns/100ps
module cev_core_event_tb;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, sup = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, pc, raddr, q;
  logic [31:0] saved [16];
  logic [3:0] be = 4'hf, rte_lvl = 4'h0;
  logic wt, ready, save, emu, crst, rres, rte = 1'b0, slow = 1'b0;
  logic [15:0] irq = 16'h0;
  cev_pkg::cev_evt_req_t event_vector_table = '0;
  cev_pkg::cev_entry_t entry;
  int miscompares = 0, n_compared = 0, cyc = 0;
  always #20 clk = ~clk;
  cev_core_event dut_u (.clk_sys_in(clk), .rst_in(rst),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_supervisor_in(sup), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wt), .evt_in(event_vector_table), .periph_irq_in(irq),
    .take_ready_in(ready), .pc_in(pc), .rte_in(rte),
    .rte_level_in(rte_lvl), .entry_out(entry), .save_state_out(save),
    .emu_mode_out(emu), .core_reset_out(crst),
    .resume_addr_out(raddr), .resume_out(rres));
  cev_core_model core_u (.clk_sys_in(clk), .rst_in(rst), .slow_in(slow),
    .entry_in(entry), .take_ready_out(ready), .pc_out(pc),
    .saved_out(saved));
  task automatic summarize();
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic s);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    sup <= s;
    rd <= ~w;
    wr <= w;
    do
      @(posedge clk);
    while (wt !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    sup <= 1'b1;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0, 1'b1);
    chk(nm, e, {16'h0, q[15:0]});
  endtask
  task automatic pulse(input cev_pkg::cev_evt_req_t e);
    @(posedge clk);
    event_vector_table <= e;
    @(posedge clk);
    event_vector_table <= '0;
  endtask
  task automatic wait_entry(input logic [3:0] lvl);
    int n;
    n = 0;
    @(negedge clk);
    while (entry.take !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    chk("take", 32'h1, {31'h0, entry.take});
    chk("level", {28'h0, lvl}, {28'h0, entry.level});
    chk("vector", 32'h0001_0000 + 32'(lvl) * 4, entry.vector);
    chk("save_state", 32'h1, {31'h0, save});
    chk("core_reset", {31'h0, lvl == 4'h1}, {31'h0, crst});
  endtask
  task automatic no_entry();
    repeat (20)
    begin
      @(negedge clk);
      chk("no_take", 32'h0, {31'h0, entry.take});
    end
  endtask
  task automatic ret(input logic [3:0] lvl);
    @(posedge clk);
    rte <= 1'b1;
    rte_lvl <= lvl;
    @(posedge clk);
    rte <= 1'b0;
    @(negedge clk);
    chk("resume", 32'h1, {31'h0, rres});
    chk("resume_addr", saved[lvl], raddr);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rchk("latch_rst", cev_pkg::OFF_LATCH, 32'h0);
    rchk("mask_rst", cev_pkg::OFF_MASK, 32'h1f);
    rchk("pend_rst", cev_pkg::OFF_PEND, 32'h0);
    bus(1'b0, cev_pkg::OFF_MASK, 32'h0, 1'b0);
    chk("user_read", 32'h0, q);
    bus(1'b1, cev_pkg::OFF_MASK, 32'hffff, 1'b0);
    rchk("user_write", cev_pkg::OFF_MASK, 32'h1f);
    rchk("unmapped", 8'h3c, 32'h0);
    bus(1'b1, cev_pkg::OFF_PEND, 32'hffff, 1'b1);
    rchk("pend_ro", cev_pkg::OFF_PEND, 32'h0);
    for (int k = 0; k < 16; k++)
      bus(1'b1, 8'(cev_pkg::OFF_VEC_BASE + 4 * k),
          32'h0001_0000 + 32'(k) * 4, 1'b1);
    bus(1'b1, cev_pkg::OFF_MASK, 32'hffff, 1'b1);
    rchk("mask_all", cev_pkg::OFF_MASK, 32'hffff);
    pulse('{emu: 1'b1, default: 1'b0});
    wait_entry(cev_pkg::LVL_EMU);
    chk("emu_on", 32'h1, {31'h0, emu});
    ret(cev_pkg::LVL_EMU);
    chk("emu_off", 32'h0, {31'h0, emu});
    pulse('{rst: 1'b1, default: 1'b0});
    wait_entry(cev_pkg::LVL_RST);
    ret(cev_pkg::LVL_RST);
    pulse('{tmr: 1'b1, default: 1'b0});
    wait_entry(cev_pkg::LVL_TMR);
    pulse('{wdog: 1'b1, default: 1'b0});
    wait_entry(cev_pkg::LVL_NMI);
    rchk("pend_nest", cev_pkg::OFF_PEND, 32'h44);
    pulse('{exc: 1'b1, default: 1'b0});
    no_entry();
    ret(cev_pkg::LVL_NMI);
    wait_entry(cev_pkg::LVL_EXC);
    ret(cev_pkg::LVL_EXC);
    ret(cev_pkg::LVL_TMR);
    pulse('{hwerr: 1'b1, default: 1'b0});
    wait_entry(cev_pkg::LVL_HWERR);
    ret(cev_pkg::LVL_HWERR);
    rchk("pend_idle", cev_pkg::OFF_PEND, 32'h0);
    bus(1'b1, cev_pkg::OFF_RAISE, 32'hc080, 1'b1);
    wait_entry(4'h7);
    ret(4'h7);
    wait_entry(4'he);
    ret(4'he);
    wait_entry(4'hf);
    ret(4'hf);
    bus(1'b1, cev_pkg::OFF_MASK, 32'hfdff, 1'b1);
    bus(1'b1, cev_pkg::OFF_RAISE, 32'h0200, 1'b1);
    no_entry();
    rchk("latched", cev_pkg::OFF_LATCH, 32'h0200);
    bus(1'b1, cev_pkg::OFF_LATCH, 32'h0200, 1'b1);
    rchk("cleared", cev_pkg::OFF_LATCH, 32'h0);
    bus(1'b1, cev_pkg::OFF_RMASK, 32'h1, 1'b1);
    bus(1'b1, cev_pkg::OFF_ASSIGN0, 32'h2, 1'b1);
    bus(1'b1, cev_pkg::OFF_ASSIGN1, 32'h3, 1'b1);
    rchk("rmask", cev_pkg::OFF_RMASK, 32'h1);
    rchk("assign1", cev_pkg::OFF_ASSIGN1, 32'h3);
    bus(1'b1, cev_pkg::OFF_MASK, 32'hffff, 1'b1);
    @(posedge clk);
    irq <= 16'h0001;
    wait_entry(4'h9);
    rchk("rstat", cev_pkg::OFF_RSTAT, 32'h1);
    irq <= 16'h0000;
    ret(4'h9);
    slow <= 1'b1;
    pulse('{nmi_pin: 1'b1, default: 1'b0});
    wait_entry(cev_pkg::LVL_NMI);
    ret(cev_pkg::LVL_NMI);
    summarize();
  end
endmodule
